/* bench/qcdp_checker.sv */
// port-level assertions for the pwm output block
`timescale 1ns/10ps
module qcdp_checker (
  input wire logic SYS_CLK_IN, // clock
  input wire logic RST_B_IN, // reset
  input wire logic PSEL_IN, // select
  input wire logic PENABLE_IN, // access
  input wire logic PWRITE_IN, // write
  input wire logic [15:0] PADDR_IN, // address
  input wire logic [31:0] PWDATA_IN, // wdata
  input wire logic [31:0] PRDATA_OUT, // rdata
  input wire logic PREADY_OUT, // ready
  input wire logic PSLVERR_OUT, // error
  input wire logic FRAME_VALID_IN, // offer
  input wire logic FRAME_READY_OUT, // room
  input wire logic [79:0] FRAME_DATA_IN, // frame
  input wire logic [3:0] SPK_P_OUT, // pos
  input wire logic [3:0] SPK_N_OUT // neg
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  logic acc, map_ok, bad, wr_ana, wr_out, rise0, p0_q, pair_r, frc_r;
  logic [10:0] age_r;
  logic [9:0] cnt_r, phi_r, nhi_r;
  logic [1:0] nrise_r;
  // decode of the current apb access
  assign acc = PSEL_IN && PENABLE_IN;
  assign map_ok = PADDR_IN inside {qcdp_pkg::MIX_ADDR, qcdp_pkg::ANA_ADDR,
    qcdp_pkg::OUTCTL_ADDR, qcdp_pkg::STAT_ADDR};
  assign bad = !map_ok || (PWRITE_IN && PADDR_IN == qcdp_pkg::STAT_ADDR);
  assign wr_ana = acc && PWRITE_IN && PADDR_IN == qcdp_pkg::ANA_ADDR;
  assign wr_out = acc && PWRITE_IN && PADDR_IN == qcdp_pkg::OUTCTL_ADDR;
  assign rise0 = SPK_P_OUT[0] && !p0_q;
  // config shadow; age restarts on each analog or output control write so settling is judged afresh
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pair_r <= 1'h0;
      frc_r <= 1'h0;
      age_r <= 11'h0;
    end else begin
      pair_r <= wr_ana ? PWDATA_IN[2] : pair_r;
      frc_r <= wr_out ? PWDATA_IN[8] : frc_r;
      age_r <= (wr_ana || wr_out) ? 11'h0 : age_r + {10'h0, age_r != 11'h7FF};
    end
  end
  // channel 1 measure; enable may land mid-period, so two rises are skipped
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      p0_q <= 1'h0;
      cnt_r <= 10'h0;
      phi_r <= 10'h0;
      nhi_r <= 10'h0;
      nrise_r <= 2'h0;
    end else begin
      p0_q <= SPK_P_OUT[0];
      cnt_r <= rise0 ? 10'h0 : cnt_r + 10'h1;
      phi_r <= rise0 ? 10'h1 : phi_r + {9'h0, SPK_P_OUT[0]};
      nhi_r <= rise0 ? {9'h0, SPK_N_OUT[0]} : nhi_r + {9'h0, SPK_N_OUT[0]};
      nrise_r <= wr_out ? 2'h0 : nrise_r + {1'h0, rise0 && nrise_r != 2'h2};
    end
  end
  a_ready_now: assert property (acc |-> PREADY_OUT)
    else $error("access phase without ready");
  a_err_map: assert property (acc |-> PSLVERR_OUT == bad)
    else $error("error flag wrong for address");
  a_err_phase: assert property (PSLVERR_OUT |-> acc)
    else $error("error outside access phase");
  a_carrier_span: assert property (rise0 && nrise_r == 2'h2 |-> cnt_r == 10'h207)
    else $error("carrier period wrong");
  a_idle_phase: assert property (rise0 && nrise_r == 2'h2 |-> $rose(SPK_N_OUT[0]))
    else $error("outputs do not start together");
  a_width_sum: assert property (rise0 && nrise_r == 2'h2 |->
    {1'h0, phi_r} + {1'h0, nhi_r} == 11'h208) else $error("widths do not sum to period");
  a_pair_copy: assert property (pair_r && age_r > 11'h640 |->
    SPK_P_OUT[2] == SPK_P_OUT[1] && SPK_N_OUT[2] == SPK_N_OUT[1])
    else $error("paired channels differ");
  a_force_idle: assert property (frc_r && age_r > 11'h640 |-> SPK_P_OUT == SPK_N_OUT)
    else $error("forced idle not balanced");
endmodule : qcdp_checker

bind qcdp_top qcdp_checker u_chk (.SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .FRAME_VALID_IN(FRAME_VALID_IN),
  .FRAME_READY_OUT(FRAME_READY_OUT), .FRAME_DATA_IN(FRAME_DATA_IN),
  .SPK_P_OUT(SPK_P_OUT), .SPK_N_OUT(SPK_N_OUT));

/* bench/qcdp_spk_load.sv */
// speaker load model measuring widths and carrier span per channel
`timescale 1ns/10ps
module qcdp_spk_load (
  input wire logic clk_in, // sample clock
  input wire logic [3:0] spk_p_in, // positive terminals
  input wire logic [3:0] spk_n_in, // negative terminals
  output logic [3:0][9:0] p_w_out, // last positive width
  output logic [3:0][9:0] n_w_out, // last negative width
  output logic [3:0][9:0] per_out, // rise to rise span
  output logic [3:0] in_ph_out // both rose together
);
  logic [3:0][9:0] cnt, ph, nh;
  logic [3:0] p_q, n_q;
  // passive load: it only integrates what the terminals show each cycle
  always @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (spk_p_in[i] && !p_q[i]) begin
        per_out[i] <= cnt[i] + 10'h1;
        p_w_out[i] <= ph[i];
        n_w_out[i] <= nh[i];
        in_ph_out[i] <= spk_n_in[i] && !n_q[i];
        cnt[i] <= 10'h0;
        ph[i] <= 10'h1;
        nh[i] <= {9'h0, spk_n_in[i]};
      end else begin
        cnt[i] <= cnt[i] + 10'h1;
        ph[i] <= ph[i] + {9'h0, spk_p_in[i]};
        nh[i] <= nh[i] + {9'h0, spk_n_in[i]};
      end
    end
    p_q <= spk_p_in;
    n_q <= spk_n_in;
  end
endmodule : qcdp_spk_load

/* bench/qcdp_top_test.sv */
// self-checking bench for the pwm output block
`timescale 1ns/10ps
module qcdp_top_test;
  logic clk, rst_b, psel, pen, pwr, fv, pready, perr, fr, er;
  logic [15:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [79:0] fd;
  logic [3:0] sp, sn, iph;
  logic [3:0][9:0] pw, nw, per;
  int bad_count = 0;
  int n_checks = 0;
  qcdp_top uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready),
    .PSLVERR_OUT(perr), .FRAME_VALID_IN(fv), .FRAME_READY_OUT(fr), .FRAME_DATA_IN(fd),
    .SPK_P_OUT(sp), .SPK_N_OUT(sn));
  qcdp_spk_load load (.clk_in(clk), .spk_p_in(sp), .spk_n_in(sn), .p_w_out(pw),
    .n_w_out(nw), .per_out(per), .in_ph_out(iph));
  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", w, e, g);
    end
  endtask : cmp
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    // no wait count is assumed; only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    // idle edge so a following call never reassigns psel in the same step
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [15:0] a, input logic [31:0] e, input logic ee);
    apb(1'h0, a, 32'h0);
    cmp("read data", e, rd);
    cmp("read error", {31'h0, ee}, {31'h0, er});
  endtask : rchk
  task automatic settle(input int n);
    repeat (n * 520) @(posedge clk);
  endtask : settle
  // widths expected around the half period for a given level
  task automatic lvl(input int c, input int l);
    cmp("pos width", 32'(qcdp_pkg::PWM_HALF_CYC + l), {22'h0, pw[c]});
    cmp("neg width", 32'(qcdp_pkg::PWM_HALF_CYC - l), {22'h0, nw[c]});
    cmp("period", qcdp_pkg::PWM_PERIOD_CYC, {22'h0, per[c]});
    cmp("in phase", 32'h1, {31'h0, iph[c]});
  endtask : lvl
  task automatic t_regs;
    rchk(qcdp_pkg::MIX_ADDR, {18'h0, qcdp_pkg::SER_VOL_RST, 2'h0, qcdp_pkg::ADC_VOL_RST},
      1'h0);
    rchk(qcdp_pkg::ANA_ADDR, 32'h0, 1'h0);
    rchk(qcdp_pkg::STAT_ADDR, 32'h2, 1'h0);
    rchk(16'h0010, 32'h0, 1'h1);
    apb(1'h1, qcdp_pkg::STAT_ADDR, 32'h1F);
    cmp("status write error", 32'h1, {31'h0, er});
    apb(1'h1, qcdp_pkg::MIX_ADDR, 32'h2A15);
    rchk(qcdp_pkg::MIX_ADDR, 32'h2A15, 1'h0);
  endtask : t_regs
  // stream one frame over and over until the fifo refuses
  task automatic t_fill;
    int n;
    n = 0;
    fd <= {{4{10'h064}}, 10'h0A0, 10'h078, 10'h050, 10'h028};
    fv <= 1'h1;
    while (fr !== 1'h0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    cmp("ready when full", 32'h0, {31'h0, fr});
  endtask : t_fill
  // serial volume codes, analog path muted by code zero
  task automatic t_serial;
    logic [5:0] code [5] = '{6'h00, 6'h3F, 6'h2F, 6'h37, 6'h33};
    int e [5] = '{0, 160, 10, 40, 20};
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, qcdp_pkg::MIX_ADDR, {18'h0, code[i], 8'h0});
      // first frame may still be one period behind in the held slot
      settle(4);
      lvl(0, e[i]);
      if (i == 1) lvl(3, 259);
    end
    for (int c = 1; c < 4; c++) lvl(c, 20 * (c + 1));
  endtask : t_serial
  task automatic t_pair;
    apb(1'h1, qcdp_pkg::OUTCTL_ADDR, 32'h0);
    apb(1'h1, qcdp_pkg::ANA_ADDR, 32'h4);
    apb(1'h1, qcdp_pkg::OUTCTL_ADDR, 32'h1);
    settle(4);
    lvl(0, 20);
    lvl(1, 40);
    lvl(2, 40);
    lvl(3, 80);
    apb(1'h1, qcdp_pkg::OUTCTL_ADDR, 32'h0);
    apb(1'h1, qcdp_pkg::ANA_ADDR, 32'h0);
    apb(1'h1, qcdp_pkg::OUTCTL_ADDR, 32'h1);
  endtask : t_pair
  // analog path at -6 dB volume (code 51) through each preamp gain
  task automatic t_analog;
    int e [4] = '{50, 65, 74, 99};
    apb(1'h1, qcdp_pkg::MIX_ADDR, 32'h0033);
    for (int g = 0; g < 4; g++) begin
      apb(1'h1, qcdp_pkg::ANA_ADDR, 32'(g));
      settle(3);
      lvl(0, e[g]);
    end
  endtask : t_analog
  task automatic t_idle(input logic [31:0] ctl, input int n);
    apb(1'h1, qcdp_pkg::OUTCTL_ADDR, ctl);
    settle(n);
    for (int c = 0; c < 4; c++) lvl(c, 0);
  endtask : t_idle
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
  initial begin
    rst_b = 1'h0;
    psel = 1'h0;
    pen = 1'h0;
    pwr = 1'h0;
    pa = 16'h0;
    pwd = 32'h0;
    fv = 1'h0;
    fd = 80'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    t_regs();
    t_idle(32'h1, 3);
    t_fill();
    t_serial();
    t_pair();
    t_analog();
    t_idle(32'h101, 4);
    apb(1'h1, qcdp_pkg::OUTCTL_ADDR, 32'h1);
    fv <= 1'h0;
    t_idle(32'h1, 8);
    rchk(qcdp_pkg::STAT_ADDR, 32'h2, 1'h0);
    give_verdict();
  end
endmodule : qcdp_top_test

/* rtl/qcdp_pkg.sv */
// shared constants, register map and sample carrier for the quad class d pwm output block
package qcdp_pkg;

  // clock and carrier timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CARRIER_HZ = 384_000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / CARRIER_HZ;
  localparam int unsigned PWM_HALF_CYC = PWM_PERIOD_CYC / 2;
  localparam int unsigned PWM_CNT_W = 10;
  localparam logic [9:0] PWM_LAST = 10'(PWM_PERIOD_CYC - 1);
  localparam logic [9:0] PWM_HALF = 10'(PWM_HALF_CYC);
  localparam logic signed [9:0] DUTY_MAX = 10'(PWM_HALF_CYC - 1);

  // sample path shape
  localparam int unsigned N_CH = 4;
  localparam int unsigned SMP_W = 10;
  localparam int unsigned FIFO_DEPTH = 4;

  // register indices; byte address is four times the index
  localparam logic [15:0] MIX_IDX = 16'h0522;
  localparam logic [15:0] ANA_IDX = 16'h0523;
  localparam logic [15:0] OUTCTL_IDX = 16'h052A;
  localparam logic [15:0] STAT_IDX = 16'h052B;
  localparam logic [15:0] MIX_ADDR = 16'(MIX_IDX * 4);
  localparam logic [15:0] ANA_ADDR = 16'(ANA_IDX * 4);
  localparam logic [15:0] OUTCTL_ADDR = 16'(OUTCTL_IDX * 4);
  localparam logic [15:0] STAT_ADDR = 16'(STAT_IDX * 4);

  // field positions
  localparam int unsigned ADC_VOL_LSB = 0;
  localparam int unsigned SER_VOL_LSB = 8;
  localparam int unsigned PRE_GAIN_LSB = 0;
  localparam int unsigned PAIRED_BIT = 2;
  localparam int unsigned OUT_EN_BIT = 0;
  localparam int unsigned IDLE_FORCE_BIT = 8;

  // values after reset
  localparam logic [5:0] ADC_VOL_RST = 6'h33;
  localparam logic [5:0] SER_VOL_RST = 6'h33;
  localparam logic [1:0] PRE_GAIN_RST = 2'h0;
  localparam logic PAIRED_RST = 1'b0;
  localparam logic OUT_EN_RST = 1'b0;
  localparam logic IDLE_FORCE_RST = 1'b0;

  // volume law: code 55 is 0 dB, each code 1.5 dB, four codes per octave
  localparam logic [6:0] VOL_BIAS = 7'h0D;
  localparam int unsigned VOL_SHIFT_BASE = 25;
  localparam logic [8:0] MANT_Q0 = 9'h100;
  localparam logic [8:0] MANT_Q1 = 9'h130;
  localparam logic [8:0] MANT_Q2 = 9'h16A;
  localparam logic [8:0] MANT_Q3 = 9'h1AF;

  // preamp gains 0, 2.4, 3.5, 6 dB in q8
  localparam logic [8:0] PRE_G0 = 9'h100;
  localparam logic [8:0] PRE_G1 = 9'h151;
  localparam logic [8:0] PRE_G2 = 9'h17F;
  localparam logic [8:0] PRE_G3 = 9'h1FF;
  localparam int unsigned PRE_SHIFT = 8;

  // one frame: every channel from both paths
  typedef struct packed {
    logic [3:0][9:0] adc;
    logic [3:0][9:0] ser;
  } qcdp_frame_t;

  localparam int unsigned FRAME_W = $bits(qcdp_frame_t);

endpackage : qcdp_pkg

/* rtl/qcdp_top.sv */
// quad class d pwm output stage: apb registers, frame fifo, mixer volume and modulators
//
// Function
// - each output pair toggles at a fixed 384 kHz carrier
// - no audio gives both outputs 50% duty and in phase
// - level widens positive pulse and narrows negative, differential is the difference
// - paired bit 2 drives channels two and three from channel two source
// - paired mode leaves channels one and four untouched
// - two-bit preamp field selects 0, 2.4, 3.5 or 6 dB
// - analog path volume from mixer register bits 5:0
// - serial path volume from mixer register bits 13:8
// - each volume has 64 steps, -82.5 to 12 dB, 1.5 dB apart
// - idle force bit 8 puts every output at 50% duty
`timescale 1ns/10ps

module qcdp_fifo #(
  parameter int unsigned WIDTH = 80,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // synced reset, active low
  input wire logic in_valid_in, // writer offers a word
  output logic in_ready_out, // room for a word
  input wire logic [WIDTH-1:0] in_data_in, // word written
  output logic out_valid_out, // word available
  input wire logic out_ready_in, // reader takes the word
  output logic [WIDTH-1:0] out_data_out, // head word
  output logic [$clog2(DEPTH):0] level_out // words held
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push;
  wire pop;

  // handshakes on both sides
  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_r[rd_ptr_r];
  assign level_out = count_r;

  // storage is plain flops, written by index
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : qcdp_fifo

module qcdp_top (
  input wire logic SYS_CLK_IN, // 200 MHz system clock
  input wire logic RST_B_IN, // async reset, active low
  input wire logic PSEL_IN, // apb select
  input wire logic PENABLE_IN, // apb access phase
  input wire logic PWRITE_IN, // apb direction, high is write
  input wire logic [15:0] PADDR_IN, // apb byte address
  input wire logic [31:0] PWDATA_IN, // apb write data
  output logic [31:0] PRDATA_OUT, // apb read data
  output logic PREADY_OUT, // apb ready
  output logic PSLVERR_OUT, // apb error on unmapped address
  input wire logic FRAME_VALID_IN, // audio frame offered
  output logic FRAME_READY_OUT, // fifo can take a frame
  input wire logic [79:0] FRAME_DATA_IN, // packed qcdp_frame_t
  output logic [3:0] SPK_P_OUT, // positive outputs, channel 1 in bit 0
  output logic [3:0] SPK_N_OUT // negative outputs, channel 1 in bit 0
);

  // reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // control fields
  logic [5:0] analog_path_volume_r;
  logic [5:0] serial_path_volume_r;
  logic [1:0] preamp_gain_select_r;
  logic paired_r;
  logic out_en_r;
  logic idle_duty_force_r;

  // apb decode, all registers one word each
  wire setup_ph = PSEL_IN & ~PENABLE_IN;
  wire access_ph = PSEL_IN & PENABLE_IN;
  wire hit_mix = (PADDR_IN == qcdp_pkg::MIX_ADDR);
  wire hit_ana = (PADDR_IN == qcdp_pkg::ANA_ADDR);
  wire hit_outctl = (PADDR_IN == qcdp_pkg::OUTCTL_ADDR);
  wire hit_stat = (PADDR_IN == qcdp_pkg::STAT_ADDR);
  wire hit_any = hit_mix | hit_ana | hit_outctl | hit_stat;
  // status is read only, so a write to it is refused like an unmapped one
  wire wr_ok = access_ph & PWRITE_IN & hit_any & ~hit_stat;
  wire bad_acc = ~hit_any | (PWRITE_IN & hit_stat);

  logic [2:0] fifo_level;
  logic fifo_out_valid;

  // read words assembled from live state
  wire [31:0] rd_mix = {18'h0, serial_path_volume_r, 2'h0, analog_path_volume_r};
  wire [31:0] rd_ana = {29'h0, paired_r, preamp_gain_select_r};
  wire [31:0] rd_outctl = {23'h0, idle_duty_force_r, 7'h0, out_en_r};
  wire [31:0] rd_stat = {27'h0, fifo_level, ~fifo_out_valid, ~FRAME_READY_OUT};
  wire [31:0] rd_sel = hit_mix ? rd_mix :
                       hit_ana ? rd_ana :
                       hit_outctl ? rd_outctl :
                       hit_stat ? rd_stat : 32'h0;

  // answer needs no wait: data and error are captured in the setup cycle
  logic [31:0] prdata_r;
  logic pslverr_r;
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= PWRITE_IN ? 32'h0 : rd_sel;
      pslverr_r <= bad_acc;
    end
  end
  assign PRDATA_OUT = prdata_r;
  assign PSLVERR_OUT = pslverr_r & access_ph;
  assign PREADY_OUT = 1'b1;

  // register writes take effect at the access edge
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      analog_path_volume_r <= qcdp_pkg::ADC_VOL_RST;
      serial_path_volume_r <= qcdp_pkg::SER_VOL_RST;
      preamp_gain_select_r <= qcdp_pkg::PRE_GAIN_RST;
      paired_r <= qcdp_pkg::PAIRED_RST;
      out_en_r <= qcdp_pkg::OUT_EN_RST;
      idle_duty_force_r <= qcdp_pkg::IDLE_FORCE_RST;
    end else if (wr_ok) begin
      if (hit_mix) begin
        analog_path_volume_r <= PWDATA_IN[qcdp_pkg::ADC_VOL_LSB +: 6];
        serial_path_volume_r <= PWDATA_IN[qcdp_pkg::SER_VOL_LSB +: 6];
      end
      if (hit_ana) begin
        preamp_gain_select_r <= PWDATA_IN[qcdp_pkg::PRE_GAIN_LSB +: 2];
        paired_r <= PWDATA_IN[qcdp_pkg::PAIRED_BIT];
      end
      if (hit_outctl) begin
        out_en_r <= PWDATA_IN[qcdp_pkg::OUT_EN_BIT];
        idle_duty_force_r <= PWDATA_IN[qcdp_pkg::IDLE_FORCE_BIT];
      end
    end
  end

  // carrier counter, one period is one 384 kHz cycle
  logic [9:0] pwm_cnt_r;
  wire period_end = (pwm_cnt_r == qcdp_pkg::PWM_LAST);
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_r <= 10'h000;
    end else begin
      pwm_cnt_r <= period_end ? 10'h000 : pwm_cnt_r + 10'h001;
    end
  end

  // frame fifo, drained once per carrier period so the source feels back-pressure
  logic [79:0] fifo_head;
  qcdp_fifo #(
    .WIDTH(qcdp_pkg::FRAME_W),
    .DEPTH(qcdp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(rst_n),
    .in_valid_in(FRAME_VALID_IN),
    .in_ready_out(FRAME_READY_OUT),
    .in_data_in(FRAME_DATA_IN),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(period_end),
    .out_data_out(fifo_head),
    .level_out(fifo_level)
  );

  // held frame; an empty fifo means silence for that period
  qcdp_pkg::qcdp_frame_t frame_r;
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= '0;
    end else if (period_end) begin
      frame_r <= fifo_out_valid ? qcdp_pkg::qcdp_frame_t'(fifo_head) : '0;
    end
  end

  // preamp gain in q8 on the analog path
  function automatic logic signed [11:0] preamp(input logic signed [9:0] x,
                                                input logic [1:0] sel);
    logic [8:0] g;
    logic signed [31:0] p;
    unique case (sel)
      2'h0: g = qcdp_pkg::PRE_G0;
      2'h1: g = qcdp_pkg::PRE_G1;
      2'h2: g = qcdp_pkg::PRE_G2;
      2'h3: g = qcdp_pkg::PRE_G3;
    endcase
    p = 32'(x) * $signed({23'h0, g});
    preamp = 12'(p >>> qcdp_pkg::PRE_SHIFT);
  endfunction : preamp

  // 1.5 dB per code: quarter-octave mantissa and a shift, code 0 is -82.5 dB
  function automatic logic signed [31:0] vol_scale(input logic signed [11:0] x,
                                                   input logic [5:0] code);
    logic [6:0] k;
    logic [8:0] mant;
    logic [4:0] sh;
    logic signed [31:0] p;
    k = {1'b0, code} + qcdp_pkg::VOL_BIAS;
    unique case (k[1:0])
      2'h0: mant = qcdp_pkg::MANT_Q0;
      2'h1: mant = qcdp_pkg::MANT_Q1;
      2'h2: mant = qcdp_pkg::MANT_Q2;
      2'h3: mant = qcdp_pkg::MANT_Q3;
    endcase
    sh = 5'(qcdp_pkg::VOL_SHIFT_BASE - 32'(k[6:2]));
    p = 32'(x) * $signed({23'h0, mant});
    vol_scale = p >>> sh;
  endfunction : vol_scale

  // mix both paths and clip to the usable duty swing
  function automatic logic signed [9:0] mix_level(input logic signed [9:0] a,
                                                  input logic signed [9:0] s,
                                                  input logic [1:0] pre,
                                                  input logic [5:0] av,
                                                  input logic [5:0] sv);
    logic signed [31:0] sum;
    sum = vol_scale(preamp(a, pre), av) + vol_scale(12'(s), sv);
    if (sum > 32'(qcdp_pkg::DUTY_MAX)) begin
      mix_level = qcdp_pkg::DUTY_MAX;
    end else if (sum < -32'(qcdp_pkg::DUTY_MAX)) begin
      mix_level = -qcdp_pkg::DUTY_MAX;
    end else begin
      mix_level = 10'(sum);
    end
  endfunction : mix_level

  // channel routing; only channel three follows the paired bit
  logic [3:0][9:0] src_adc;
  logic [3:0][9:0] src_ser;
  always_comb begin
    src_adc = frame_r.adc;
    src_ser = frame_r.ser;
    if (paired_r) begin
      src_adc[2] = frame_r.adc[1];
      src_ser[2] = frame_r.ser[1];
    end
    // channels 1 and 4 take their own slots whatever the paired bit says
  end

  // per-channel level and pulse widths for the coming period
  logic signed [3:0][9:0] level;
  logic [3:0][9:0] wpos_nxt;
  logic [3:0][9:0] wneg_nxt;
  always_comb begin
    for (int c = 0; c < qcdp_pkg::N_CH; c++) begin
      level[c] = mix_level(src_adc[c], src_ser[c], preamp_gain_select_r,
                           analog_path_volume_r, serial_path_volume_r);
      if (idle_duty_force_r) begin
        level[c] = 10'sh000;
      end
      wpos_nxt[c] = qcdp_pkg::PWM_HALF + 10'(level[c]);
      wneg_nxt[c] = qcdp_pkg::PWM_HALF - 10'(level[c]);
    end
  end

  // widths change only at a period boundary so no pulse is cut short
  logic [3:0][9:0] wpos_r;
  logic [3:0][9:0] wneg_r;
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wpos_r <= {4{qcdp_pkg::PWM_HALF}};
      wneg_r <= {4{qcdp_pkg::PWM_HALF}};
    end else if (period_end) begin
      wpos_r <= wpos_nxt;
      wneg_r <= wneg_nxt;
    end
  end

  // both outputs rise together at period start, so equal widths are in phase
  logic [3:0] p_nxt;
  logic [3:0] n_nxt;
  always_comb begin
    for (int c = 0; c < qcdp_pkg::N_CH; c++) begin
      p_nxt[c] = out_en_r & (pwm_cnt_r < wpos_r[c]);
      n_nxt[c] = out_en_r & (pwm_cnt_r < wneg_r[c]);
    end
  end

  // outputs from flops; disabled outputs sit low on both sides
  logic [3:0] spk_p_r;
  logic [3:0] spk_n_r;
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      spk_p_r <= 4'h0;
      spk_n_r <= 4'h0;
    end else begin
      spk_p_r <= p_nxt;
      spk_n_r <= n_nxt;
    end
  end
  assign SPK_P_OUT = spk_p_r;
  assign SPK_N_OUT = spk_n_r;

  // host orders paired mode before enabling the joined pair; nothing here enforces it

endmodule : qcdp_top
